// ==== core/word_stack_push_pop_unit.sv ====
// word stack engine: push, pop newest, pop oldest, with pointer and fault flag
// assumes the sequencer is on ref_clk and issues one operation per cycle with execute high
module word_stack_push_pop_unit (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // operation request
  input wire logic execute,
  input wire stack_pkg::stack_op_t opSel,
  input wire logic [stack_pkg::WORD_W-1:0] pushWord,
  input wire logic [stack_pkg::PTR_W-1:0] stackSize,
  // results
  output logic [stack_pkg::WORD_W-1:0] popWord,
  output logic [stack_pkg::PTR_W-1:0] stackPtr,
  output logic statusOut,
  output logic fault_indicator,
  output logic popValid
);

  stack_cell_if cellBus ();
  logic [stack_pkg::PTR_W-1:0] ptr_q, ptr_d;
  logic [stack_pkg::WORD_W-1:0] popWord_q, popWord_d;
  logic status_q, status_d, fault_q, fault_d, popValid_q, popValid_d;

  stack_store u_store (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cellBus(cellBus)
  );

  // pointer classes: the pointer is signed, the valid range is 0..size
  wire signed [stack_pkg::PTR_W-1:0] ptrS = $signed(ptr_q);
  wire ptrNeg = ptrS < 0;
  wire outRange = ptrNeg || (ptr_q > stackSize);
  wire isEmpty = !ptrNeg && (ptr_q == stack_pkg::PTR_RESET);
  wire isLast = (ptr_q == stack_pkg::SIZE_MIN);
  wire isFull = !outRange && (ptr_q == stackSize);

  // operation decode, only while execute is high
  wire doPush = execute && (opSel == stack_pkg::OP_PUSH);
  wire doNewest = execute && (opSel == stack_pkg::OP_POP_NEWEST);
  wire doOldest = execute && (opSel == stack_pkg::OP_POP_OLDEST);
  wire popOk = !outRange && !isEmpty;

  // read selection: newest at the head, oldest at pointer minus one
  wire [stack_pkg::IDX_W-1:0] oldIdx = stack_pkg::IDX_W'(ptr_q - stack_pkg::SIZE_MIN);
  wire [stack_pkg::WORD_W-1:0] newestWord = cellBus.cells[0];
  wire [stack_pkg::WORD_W-1:0] oldestWord = cellBus.cells[oldIdx];

  assign cellBus.shiftDown = doPush;
  assign cellBus.shiftUp = doNewest && popOk;
  assign cellBus.headWord = pushWord;

  // next-state for pointer, output word and flags
  // a refused pop leaves pointer and word alone, so a sequencer that
  // ignores the fault pulse still sees a consistent stack afterwards
  // pop newest on an empty stack is handled like pop oldest: status, no fault
  always_comb begin
    ptr_d = ptr_q;
    popWord_d = popWord_q;
    status_d = 1'b0;
    fault_d = 1'b0;
    popValid_d = 1'b0;
    if (doPush) begin
      if (isFull) status_d = 1'b1;
      else ptr_d = ptr_q + stack_pkg::SIZE_MIN;
    end else if (doNewest || doOldest) begin
      if (outRange) begin
        fault_d = 1'b1;
      end else if (isEmpty) begin
        status_d = 1'b1;
      end else begin
        popWord_d = doNewest ? newestWord : oldestWord;
        ptr_d = ptr_q - stack_pkg::SIZE_MIN;
        popValid_d = 1'b1;
        status_d = isLast;
      end
    end
  end

  // registered state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_q <= stack_pkg::PTR_RESET;
      popWord_q <= stack_pkg::WORD_RESET;
      status_q <= 1'b0;
      fault_q <= 1'b0;
      popValid_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      popWord_q <= popWord_d;
      status_q <= status_d;
      fault_q <= fault_d;
      popValid_q <= popValid_d;
    end
  end

  assign popWord = popWord_q;
  assign stackPtr = ptr_q;
  assign statusOut = status_q;
  assign fault_indicator = fault_q;
  assign popValid = popValid_q;

  // checks
  chk_idle_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    !execute |=> !statusOut && !fault_indicator && $stable(stackPtr)) else $error("idle changed state");
  chk_push_inc: assert property (@(posedge ref_clk) disable iff (!nrst)
    doPush && !isFull |=> stackPtr == $past(ptr_q) + 16'h0001 && !statusOut) else $error("push pointer wrong");
  chk_push_full: assert property (@(posedge ref_clk) disable iff (!nrst)
    doPush && isFull |=> $stable(stackPtr) && statusOut) else $error("full push wrong");
  chk_push_head: assert property (@(posedge ref_clk) disable iff (!nrst)
    doPush |=> cellBus.cells[0] == $past(pushWord)) else $error("push word not at head");
  chk_newest_copy: assert property (@(posedge ref_clk) disable iff (!nrst)
    doNewest && popOk |=> popWord == $past(newestWord) && stackPtr == $past(ptr_q) - 16'h0001)
    else $error("pop newest wrong");
  chk_newest_shift: assert property (@(posedge ref_clk) disable iff (!nrst)
    doNewest && popOk |=> cellBus.cells[0] == $past(cellBus.cells[1])) else $error("no shift up");
  chk_oldest_copy: assert property (@(posedge ref_clk) disable iff (!nrst)
    doOldest && popOk |=> popWord == $past(oldestWord) && $stable(cellBus.cells[0]))
    else $error("pop oldest wrong");
  chk_range_fault: assert property (@(posedge ref_clk) disable iff (!nrst)
    (doNewest || doOldest) && outRange |=> fault_indicator && !statusOut && $stable(stackPtr))
    else $error("range fault missing");
  chk_empty_high: assert property (@(posedge ref_clk) disable iff (!nrst)
    doOldest && isEmpty |=> statusOut && !popValid && $stable(popWord)) else $error("empty pop wrong");
  chk_last_pop: assert property (@(posedge ref_clk) disable iff (!nrst)
    (doNewest || doOldest) && isLast |=> statusOut && stackPtr == 16'h0000) else $error("last pop wrong");

  // named steps shared by the checks below
  sequence seqPopGood;
    (doNewest || doOldest) && popOk;
  endsequence
  sequence seqPopBad;
    (doNewest || doOldest) && outRange;
  endsequence
  sequence seqPopEmpty;
    (doNewest || doOldest) && isEmpty;
  endsequence
  sequence seqPushFull;
    doPush && isFull;
  endsequence
  sequence seqPopResult;
    popValid && !fault_indicator;
  endsequence

  // pop oldest out of range: fault pulse, word and pointer kept
  chk_oldest_fault: assert property (@(posedge ref_clk) disable iff (!nrst)
    doOldest && outRange |=> fault_indicator && !statusOut && !popValid && $stable(popWord) && $stable(stackPtr))
    else $error("pop oldest range fault wrong");
  // pop newest out of range: fault pulse, word and pointer kept
  chk_newest_fault: assert property (@(posedge ref_clk) disable iff (!nrst)
    doNewest && outRange |=> fault_indicator && !popValid && $stable(popWord) && $stable(stackPtr))
    else $error("pop newest range fault wrong");
  // a fault pulse only follows a refused pop
  chk_fault_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    fault_indicator |-> $past(doNewest || doOldest) && $past(outRange))
    else $error("fault without cause");
  // a good pop gives a result pulse
  chk_pop_good: assert property (@(posedge ref_clk) disable iff (!nrst)
    seqPopGood |=> seqPopResult)
    else $error("good pop gave no result");
  // a pop that leaves words behind keeps the output low
  chk_pop_status: assert property (@(posedge ref_clk) disable iff (!nrst)
    (doNewest || doOldest) && popOk && !isLast |=> !statusOut)
    else $error("status high with words left");
  // a refused pop never shows status or a result
  chk_bad_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    seqPopBad |=> !statusOut && !popValid)
    else $error("refused pop showed a result");
  // pop on an empty stack: status high, no fault, pointer kept
  chk_empty_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    seqPopEmpty |=> statusOut && !fault_indicator && $stable(stackPtr))
    else $error("empty pop not quiet");
  // pop on an empty stack leaves the word alone
  chk_empty_word: assert property (@(posedge ref_clk) disable iff (!nrst)
    seqPopEmpty |=> !popValid && $stable(popWord))
    else $error("empty pop changed word");
  // push on a full stack still shifts the words down
  chk_full_shift: assert property (@(posedge ref_clk) disable iff (!nrst)
    seqPushFull |=> cellBus.cells[1] == $past(cellBus.cells[0]))
    else $error("full push did not shift");
  // pop oldest leaves the other words and drops the pointer by one
  chk_oldest_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
    doOldest && popOk |=> $stable(cellBus.cells[1]) && stackPtr == $past(ptr_q) - 16'h0001)
    else $error("pop oldest moved words");
  // pop oldest takes the word at pointer minus one
  chk_oldest_slot: assert property (@(posedge ref_clk) disable iff (!nrst)
    doOldest && popOk |=> popWord == $past(cellBus.cells[ptr_q[stack_pkg::IDX_W-1:0] - 6'h01]))
    else $error("pop oldest wrong slot");
  // status pulses only after an executed operation
  chk_status_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    statusOut |-> $past(execute))
    else $error("status without execute");
  // result pulses only after an executed pop
  chk_valid_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    popValid |-> $past(execute) && $past(doNewest || doOldest))
    else $error("result without pop");
  // push keeps the pointer inside the size
  chk_ptr_bounded: assert property (@(posedge ref_clk) disable iff (!nrst)
    doPush && !outRange |=> stackPtr <= stackSize)
    else $error("pointer above size");
  // push raises no fault and no result
  chk_push_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    doPush |=> !fault_indicator && !popValid)
    else $error("push raised a pulse");
  // pop newest moves the deeper words up as well
  chk_newest_deep: assert property (@(posedge ref_clk) disable iff (!nrst)
    doNewest && popOk |=> cellBus.cells[1] == $past(cellBus.cells[2]))
    else $error("deep words not moved up");
  // push leaves the popped word alone
  chk_push_word: assert property (@(posedge ref_clk) disable iff (!nrst)
    doPush |=> $stable(popWord))
    else $error("push changed popped word");
  // a refused pop leaves the storage alone
  chk_bad_cells: assert property (@(posedge ref_clk) disable iff (!nrst)
    seqPopBad |=> $stable(cellBus.cells[0]))
    else $error("refused pop moved words");
  // a result pulse never comes with a fault
  chk_result_clean: assert property (@(posedge ref_clk) disable iff (!nrst)
    popValid |-> !fault_indicator)
    else $error("result with fault");
  // idle cycles leave the storage alone
  chk_idle_cells: assert property (@(posedge ref_clk) disable iff (!nrst)
    !execute |=> $stable(cellBus.cells[0]))
    else $error("idle moved words");
endmodule

// ==== inc/stack_pkg.sv ====
// constants and types for the word stack push/pop unit
// assumes a single 50 MHz clock domain, operations issued by a program sequencer
// How it works
// - push when not full shifts, increments pointer
// - push when full drops last, pointer held
// - pop newest copies first entry, decrements pointer
// - after pop newest remaining words move up
// - pop newest out of range sets fault
// - pop oldest copies lowest occupied entry
// - oldest entry sits at pointer minus one
// - pop oldest on empty stack outputs high
// - pop oldest out of range sets fault
package stack_pkg;
  localparam int WORD_W = 16;
  localparam int DEPTH = 64;
  localparam int IDX_W = 6;
  localparam int PTR_W = 16;
  localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [PTR_W-1:0] SIZE_MIN = 16'h0001;
  localparam logic [PTR_W-1:0] SIZE_MAX = 16'h0040;
  typedef enum logic [1:0] {
    OP_PUSH = 2'h0,
    OP_POP_NEWEST = 2'h1,
    OP_POP_OLDEST = 2'h2,
    OP_NONE = 2'h3
  } stack_op_t;
endpackage

// ==== inc/stack_cell_if.sv ====
// carrier between the stack top and its storage cells
// assumes all cells are clocked by ref_clk
interface stack_cell_if;
  logic shiftDown;
  logic shiftUp;
  logic [stack_pkg::WORD_W-1:0] headWord;
  logic [stack_pkg::WORD_W-1:0] cells [stack_pkg::DEPTH];
  modport ctrl (output shiftDown, output shiftUp, output headWord, input cells);
  modport store (input shiftDown, input shiftUp, input headWord, output cells);
endinterface

// ==== core/stack_store.sv ====
// storage of 64 words that shift down on push and up on pop newest
// assumes shiftDown and shiftUp are never high together
module stack_store (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // control and words
  stack_cell_if.store cellBus
);
  logic [stack_pkg::WORD_W-1:0] cellQ [stack_pkg::DEPTH];

  // shift register: push moves words to higher index, pop newest to lower
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < stack_pkg::DEPTH; i++) cellQ[i] <= stack_pkg::WORD_RESET;
    end else if (cellBus.shiftDown) begin
      cellQ[0] <= cellBus.headWord;
      for (int i = 1; i < stack_pkg::DEPTH; i++) cellQ[i] <= cellQ[i-1];
    end else if (cellBus.shiftUp) begin
      for (int i = 0; i < stack_pkg::DEPTH - 1; i++) cellQ[i] <= cellQ[i+1];
      cellQ[stack_pkg::DEPTH-1] <= stack_pkg::WORD_RESET;
    end
  end

  assign cellBus.cells = cellQ;
endmodule

// ==== verification/size_source.sv ====
// partner model: the sequencer side that supplies the stack size operand
// assumes the size stays fixed except while the test drives shrink
module size_source #(
  parameter logic [stack_pkg::PTR_W-1:0] SIZE = 16'h0004,
  parameter logic [stack_pkg::PTR_W-1:0] SIZE_SMALL = 16'h0001
) (
  // test control: pick the small size
  input wire logic shrink,
  // operand to the stack unit
  output logic [stack_pkg::PTR_W-1:0] stackSize
);
  timeunit 1ns;
  timeprecision 1ps;
  // size kept inside one to 64 words
  assign stackSize = shrink ? SIZE_SMALL : SIZE;
endmodule

// ==== verification/test_word_stack_push_pop_unit.sv ====
// testbench for the word stack unit: push, pop newest, pop oldest, full and empty cases
// assumes a stack size of four words from the partner model
module test_word_stack_push_pop_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic execute = 1'b0;
  stack_pkg::stack_op_t opSel = stack_pkg::OP_NONE;
  logic [15:0] pushWord = 16'h0000;
  logic [15:0] stackSize, popWord, stackPtr;
  logic statusOut, fault_indicator, popValid;
  logic shrink = 1'b0;
  logic expFault = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  size_source u_size_source (.shrink(shrink), .stackSize(stackSize));
  word_stack_push_pop_unit u_word_stack_push_pop_unit (.ref_clk(ref_clk), .nrst(nrst), .execute(execute),
    .opSel(opSel), .pushWord(pushWord), .stackSize(stackSize), .popWord(popWord), .stackPtr(stackPtr),
    .statusOut(statusOut), .fault_indicator(fault_indicator), .popValid(popValid));
  // compare one value and count it
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one operation, taken at the next edge, results checked just after
  task automatic op(input stack_pkg::stack_op_t o, input logic [15:0] w, input logic ex);
    @(posedge ref_clk);
    execute <= ex;
    opSel <= o;
    pushWord <= w;
    @(posedge ref_clk);
    execute <= 1'b0;
    #1;
    chk("fault", {15'h0, fault_indicator}, {15'h0, expFault});
  endtask
  // pushes then newest pops, second pop sees the word moved up
  task automatic scen_push_pop;
    op(stack_pkg::OP_PUSH, 16'h0011, 1'b1);
    chk("ptr", stackPtr, 16'h0001);
    chk("status", {15'h0, statusOut}, 16'h0000);
    op(stack_pkg::OP_PUSH, 16'h0022, 1'b1);
    op(stack_pkg::OP_PUSH, 16'h0033, 1'b1);
    op(stack_pkg::OP_POP_NEWEST, 16'h0000, 1'b1);
    chk("pop", popWord, 16'h0033);
    chk("ptr", stackPtr, 16'h0002);
    chk("valid", {15'h0, popValid}, 16'h0001);
    op(stack_pkg::OP_POP_NEWEST, 16'h0000, 1'b1);
    chk("pop", popWord, 16'h0022);
  endtask
  // fill to four, push once more onto the full stack
  task automatic scen_full;
    op(stack_pkg::OP_PUSH, 16'h0044, 1'b1);
    op(stack_pkg::OP_PUSH, 16'h0055, 1'b1);
    op(stack_pkg::OP_PUSH, 16'h0066, 1'b1);
    op(stack_pkg::OP_PUSH, 16'h0077, 1'b1);
    chk("ptr", stackPtr, 16'h0004);
    chk("status", {15'h0, statusOut}, 16'h0001);
  endtask
  // oldest pops after the bottom word was dropped
  task automatic scen_oldest;
    op(stack_pkg::OP_POP_OLDEST, 16'h0000, 1'b1);
    chk("pop", popWord, 16'h0044);
    chk("ptr", stackPtr, 16'h0003);
    op(stack_pkg::OP_POP_OLDEST, 16'h0000, 1'b1);
    chk("pop", popWord, 16'h0055);
  endtask
  // drain to empty, then pop on an empty stack and an idle cycle
  task automatic scen_empty;
    op(stack_pkg::OP_POP_NEWEST, 16'h0000, 1'b1);
    op(stack_pkg::OP_POP_NEWEST, 16'h0000, 1'b1);
    chk("pop", popWord, 16'h0066);
    chk("status", {15'h0, statusOut}, 16'h0001);
    op(stack_pkg::OP_POP_OLDEST, 16'h0000, 1'b1);
    chk("status", {15'h0, statusOut}, 16'h0001);
    chk("valid", {15'h0, popValid}, 16'h0000);
    chk("pop", popWord, 16'h0066);
    op(stack_pkg::OP_PUSH, 16'h0088, 1'b0);
    chk("ptr", stackPtr, 16'h0000);
    chk("status", {15'h0, statusOut}, 16'h0000);
  endtask
  // size shrunk below the pointer: both pops refused with a fault
  task automatic scen_fault;
    op(stack_pkg::OP_PUSH, 16'h0091, 1'b1);
    op(stack_pkg::OP_PUSH, 16'h0092, 1'b1);
    @(posedge ref_clk);
    shrink <= 1'b1;
    expFault = 1'b1;
    op(stack_pkg::OP_POP_NEWEST, 16'h0000, 1'b1);
    chk("ptr", stackPtr, 16'h0002);
    chk("valid", {15'h0, popValid}, 16'h0000);
    op(stack_pkg::OP_POP_OLDEST, 16'h0000, 1'b1);
    chk("status", {15'h0, statusOut}, 16'h0000);
    chk("pop", popWord, 16'h0066);
    expFault = 1'b0;
    @(posedge ref_clk);
    shrink <= 1'b0;
    op(stack_pkg::OP_POP_NEWEST, 16'h0000, 1'b1);
    chk("pop", popWord, 16'h0092);
  endtask
  // counts, verdict and end of run
  task automatic final_report;
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog far beyond the expected run
  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    scen_push_pop();
    scen_full();
    scen_oldest();
    scen_empty();
    scen_fault();
    final_report();
  end
endmodule
